// ### shared/bsfx_pkg.sv
package bsfx_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int          ADDR_W       = 12;
    localparam logic [11:0] OFS_CMD      = 12'h000;
    localparam logic [11:0] OFS_STATUS   = 12'h004;
    localparam logic [11:0] OFS_FLAGS    = 12'h008;
    localparam logic [11:0] OFS_SP       = 12'h00C;
    localparam logic [3:0]  WIN_WREG     = 4'h1;
    localparam logic [3:0]  WIN_IO       = 4'h2;
    localparam logic [3:0]  WIN_STK      = 4'h3;
    // ----------------------------------------
    // command fields
    // ----------------------------------------
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_OP_W    = 4;
    localparam int CMD_RD_LSB  = 4;
    localparam int CMD_RD_W    = 5;
    localparam int CMD_BIT_LSB = 9;
    localparam int CMD_BIT_W   = 3;
    localparam int CMD_IO_LSB  = 12;
    localparam int CMD_IO_W    = 5;
    localparam int CMD_W       = 17;
    // ----------------------------------------
    // operation codes
    // ----------------------------------------
    localparam logic [3:0] OP_NOP                 = 4'h0;
    localparam logic [3:0] OP_PUSH                = 4'h1;
    localparam logic [3:0] OP_POP                 = 4'h2;
    localparam logic [3:0] OP_IO_BIT_SET          = 4'h3;
    localparam logic [3:0] OP_IO_BIT_CLEAR        = 4'h4;
    localparam logic [3:0] OP_SHIFT_LEFT_LOGICAL  = 4'h5;
    localparam logic [3:0] OP_SHIFT_RIGHT_LOGICAL = 4'h6;
    localparam logic [3:0] OP_ROTATE_LEFT_CARRY   = 4'h7;
    localparam logic [3:0] OP_ROTATE_RIGHT_CARRY  = 4'h8;
    localparam logic [3:0] OP_SHIFT_RIGHT_ARITH   = 4'h9;
    localparam logic [3:0] OP_NIBBLE_SWAP         = 4'hA;
    localparam logic [3:0] OP_BIT_TO_XFER_FLAG    = 4'hB;
    localparam logic [3:0] OP_XFER_FLAG_TO_BIT    = 4'hC;
    localparam logic [3:0] OP_FLAG_SET            = 4'hD;
    localparam logic [3:0] OP_FLAG_CLEAR          = 4'hE;
    localparam logic [3:0] OP_SLEEP               = 4'hF;
    // ----------------------------------------
    // status flag positions and reset values
    // ----------------------------------------
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_S = 4;
    localparam int FLG_H = 5;
    localparam int FLG_T = 6;
    localparam int FLG_I = 7;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam int STS_BUSY  = 0;
    localparam int STS_SLEEP = 1;
    localparam int STS_SP    = 8;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CYC_SHORT = 1;
    localparam int CYC_LONG  = 2;
endpackage : bsfx_pkg

// ### shared/bsfx_alu_if.sv
`timescale 1ns/1ps
interface bsfx_alu_if;
    logic [3:0] op;
    logic [7:0] opnd;
    logic [2:0] bsel;
    logic [7:0] flags;
    logic [7:0] res;
    logic [7:0] flags_n;
    logic       wr_res;
    logic       wr_flags;
    modport exec (output op, opnd, bsel, flags, input res, flags_n, wr_res, wr_flags);
    modport alu  (input op, opnd, bsel, flags, output res, flags_n, wr_res, wr_flags);
endinterface : bsfx_alu_if

// ### src/bsfx_shift_alu.sv
`timescale 1ns/1ps
module bsfx_shift_alu (
    bsfx_alu_if.alu a
);
    logic [7:0] r;
    logic [7:0] f;
    logic       c;
    logic       upd;

    // ----------------------------------------
    // shifter and flag logic
    // ----------------------------------------
    always_comb begin
        r   = a.opnd;
        f   = a.flags;
        c   = a.flags[bsfx_pkg::FLG_C];
        upd = 1'b0;
        a.wr_res   = 1'b0;
        a.wr_flags = 1'b0;
        case (a.op)
            bsfx_pkg::OP_SHIFT_LEFT_LOGICAL: begin
                r = {a.opnd[6:0], 1'b0};
                c = a.opnd[7];
                upd = 1'b1;
            end
            bsfx_pkg::OP_SHIFT_RIGHT_LOGICAL: begin
                r = {1'b0, a.opnd[7:1]};
                c = a.opnd[0];
                upd = 1'b1;
            end
            bsfx_pkg::OP_ROTATE_LEFT_CARRY: begin
                r = {a.opnd[6:0], a.flags[bsfx_pkg::FLG_C]};
                c = a.opnd[7];
                upd = 1'b1;
            end
            bsfx_pkg::OP_ROTATE_RIGHT_CARRY: begin
                r = {a.flags[bsfx_pkg::FLG_C], a.opnd[7:1]};
                c = a.opnd[0];
                upd = 1'b1;
            end
            bsfx_pkg::OP_SHIFT_RIGHT_ARITH: begin
                r = {a.opnd[7], a.opnd[7:1]};
                c = a.opnd[0];
                upd = 1'b1;
            end
            bsfx_pkg::OP_NIBBLE_SWAP: begin
                r = {a.opnd[3:0], a.opnd[7:4]};
                a.wr_res = 1'b1;
            end
            bsfx_pkg::OP_BIT_TO_XFER_FLAG: begin
                f[bsfx_pkg::FLG_T] = a.opnd[a.bsel];
                a.wr_flags = 1'b1;
            end
            bsfx_pkg::OP_XFER_FLAG_TO_BIT: begin
                r[a.bsel] = a.flags[bsfx_pkg::FLG_T];
                a.wr_res = 1'b1;
            end
            bsfx_pkg::OP_FLAG_SET: begin
                f[a.bsel] = 1'b1;
                a.wr_flags = 1'b1;
            end
            bsfx_pkg::OP_FLAG_CLEAR: begin
                f[a.bsel] = 1'b0;
                a.wr_flags = 1'b1;
            end
            default: begin
                r = a.opnd;
            end
        endcase
        if (upd) begin
            f[bsfx_pkg::FLG_C] = c;
            f[bsfx_pkg::FLG_Z] = (r == 8'h00);
            f[bsfx_pkg::FLG_N] = r[7];
            f[bsfx_pkg::FLG_V] = r[7] ^ c;
            a.wr_res   = 1'b1;
            a.wr_flags = 1'b1;
        end
        a.res    = r;
        a.flags_n = f;
    end
endmodule : bsfx_shift_alu

// ### src/bsfx_exec_unit.sv
`timescale 1ns/1ps
module bsfx_exec_unit #(
    parameter int NUM_WREG  = 32,
    parameter int NUM_IO    = 32,
    parameter int STK_DEPTH = 16
) (
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        wake_i,
    output logic             busy_o,
    output logic             sleep_o
);
    localparam int SPW = $clog2(STK_DEPTH);
    localparam logic [SPW-1:0] SP_RST = SPW'(STK_DEPTH - 1);

    typedef enum logic [1:0] {
        BSFX_IDLE,
        BSFX_RUN1,
        BSFX_RUN2
    } bsfx_state_t;

    typedef enum logic [2:0] {
        BSFX_A_CMD,
        BSFX_A_STATUS,
        BSFX_A_FLAGS,
        BSFX_A_SP,
        BSFX_A_WREG,
        BSFX_A_IO,
        BSFX_A_STK,
        BSFX_A_NONE
    } bsfx_area_t;

    // ----------------------------------------
    // state
    // ----------------------------------------
    bsfx_state_t               state_ff;
    bsfx_state_t               nxt_state;
    logic [bsfx_pkg::CMD_W-1:0] cmd_ff;
    logic [bsfx_pkg::CMD_W-1:0] nxt_cmd;
    logic [7:0]                wreg_ff [NUM_WREG];
    logic [7:0]                nxt_wreg [NUM_WREG];
    logic [7:0]                io_ff [NUM_IO];
    logic [7:0]                nxt_io [NUM_IO];
    logic [7:0]                stk_ff [STK_DEPTH];
    logic [7:0]                nxt_stk [STK_DEPTH];
    logic [SPW-1:0]            sp_ff;
    logic [SPW-1:0]            nxt_sp;
    logic [7:0]                flags_ff;
    logic [7:0]                nxt_flags;
    logic                      sleep_ff;
    logic                      nxt_sleep;
    logic                      wk_s1_ff;
    logic                      wk_s2_ff;
    logic [31:0]               prdata_ff;
    logic [31:0]               nxt_prdata;
    logic                      err_ff;
    logic                      nxt_err;

    logic [3:0]                op;
    logic [4:0]                rd;
    logic [2:0]                bsel;
    logic [4:0]                ioa;
    logic                      long_op;
    bsfx_area_t                area;
    logic [5:0]                widx;
    logic                      setup;
    logic                      access;

    bsfx_alu_if alu_bus ();

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic bsfx_area_t decode(input logic [11:0] a);
        logic [5:0] ix;
        ix = a[7:2];
        decode = BSFX_A_NONE;
        if (a[1:0] != 2'b00) begin
            decode = BSFX_A_NONE;
        end else if (a == bsfx_pkg::OFS_CMD) begin
            decode = BSFX_A_CMD;
        end else if (a == bsfx_pkg::OFS_STATUS) begin
            decode = BSFX_A_STATUS;
        end else if (a == bsfx_pkg::OFS_FLAGS) begin
            decode = BSFX_A_FLAGS;
        end else if (a == bsfx_pkg::OFS_SP) begin
            decode = BSFX_A_SP;
        end else if (a[11:8] == bsfx_pkg::WIN_WREG && 32'(ix) < NUM_WREG) begin
            decode = BSFX_A_WREG;
        end else if (a[11:8] == bsfx_pkg::WIN_IO && 32'(ix) < NUM_IO) begin
            decode = BSFX_A_IO;
        end else if (a[11:8] == bsfx_pkg::WIN_STK && 32'(ix) < STK_DEPTH) begin
            decode = BSFX_A_STK;
        end
    endfunction : decode

    function automatic logic is_long(input logic [3:0] o);
        is_long = (o == bsfx_pkg::OP_PUSH) || (o == bsfx_pkg::OP_POP) ||
                  (o == bsfx_pkg::OP_IO_BIT_SET) || (o == bsfx_pkg::OP_IO_BIT_CLEAR);
    endfunction : is_long

    assign area   = decode(paddr_i);
    assign widx   = paddr_i[7:2];
    assign setup  = psel_i && !penable_i;
    assign access = psel_i && penable_i;

    assign op      = cmd_ff[bsfx_pkg::CMD_OP_LSB +: bsfx_pkg::CMD_OP_W];
    assign rd      = cmd_ff[bsfx_pkg::CMD_RD_LSB +: bsfx_pkg::CMD_RD_W];
    assign bsel    = cmd_ff[bsfx_pkg::CMD_BIT_LSB +: bsfx_pkg::CMD_BIT_W];
    assign ioa     = cmd_ff[bsfx_pkg::CMD_IO_LSB +: bsfx_pkg::CMD_IO_W];
    assign long_op = is_long(op);

    // ----------------------------------------
    // shifter hookup
    // ----------------------------------------
    assign alu_bus.op   = op;
    assign alu_bus.opnd = wreg_ff[rd];
    assign alu_bus.bsel = bsel;
    assign alu_bus.flags = flags_ff;

    bsfx_shift_alu u_alu (
        .a (alu_bus)
    );

    // ----------------------------------------
    // apb read path and error check
    // ----------------------------------------
    always_comb begin
        nxt_prdata = prdata_ff;
        nxt_err    = err_ff;
        if (setup) begin
            nxt_prdata = 32'h0000_0000;
            nxt_err    = 1'b0;
            case (area)
                BSFX_A_CMD:    nxt_prdata = 32'(cmd_ff);
                BSFX_A_STATUS: begin
                    nxt_prdata[bsfx_pkg::STS_BUSY]  = (state_ff != BSFX_IDLE);
                    nxt_prdata[bsfx_pkg::STS_SLEEP] = sleep_ff;
                    nxt_prdata[bsfx_pkg::STS_SP +: SPW] = sp_ff;
                end
                BSFX_A_FLAGS:  nxt_prdata = 32'(flags_ff);
                BSFX_A_SP:     nxt_prdata = 32'(sp_ff);
                BSFX_A_WREG:   nxt_prdata = 32'(wreg_ff[widx[4:0]]);
                BSFX_A_IO:     nxt_prdata = 32'(io_ff[widx[4:0]]);
                BSFX_A_STK:    nxt_prdata = 32'(stk_ff[widx[SPW-1:0]]);
                default:       nxt_err = 1'b1;
            endcase
            if (pwrite_i && area == BSFX_A_STATUS) begin
                nxt_err = 1'b1;
            end
            if (pwrite_i && (state_ff != BSFX_IDLE || sleep_ff)) begin
                nxt_err = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            prdata_ff <= 32'h0000_0000;
            err_ff    <= 1'b0;
        end else begin
            prdata_ff <= nxt_prdata;
            err_ff    <= nxt_err;
        end
    end

    assign prdata_o  = prdata_ff;
    assign pready_o  = 1'b1;
    assign pslverr_o = access && err_ff;

    // ----------------------------------------
    // execution engine
    // ----------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_cmd   = cmd_ff;
        nxt_wreg  = wreg_ff;
        nxt_io    = io_ff;
        nxt_stk   = stk_ff;
        nxt_sp    = sp_ff;
        nxt_flags = flags_ff;
        nxt_sleep = sleep_ff && !wk_s2_ff;
        if (access && pwrite_i && !err_ff) begin
            case (area)
                BSFX_A_CMD: begin
                    nxt_cmd   = pwdata_i[bsfx_pkg::CMD_W-1:0];
                    nxt_state = BSFX_RUN1;
                end
                BSFX_A_FLAGS: nxt_flags = pwdata_i[7:0];
                BSFX_A_SP:   nxt_sp = pwdata_i[SPW-1:0];
                BSFX_A_WREG: nxt_wreg[widx[4:0]] = pwdata_i[7:0];
                BSFX_A_IO:   nxt_io[widx[4:0]] = pwdata_i[7:0];
                BSFX_A_STK:  nxt_stk[widx[SPW-1:0]] = pwdata_i[7:0];
                default:     nxt_state = state_ff;
            endcase
        end
        case (state_ff)
            BSFX_IDLE: begin
                nxt_sleep = nxt_sleep;
            end
            BSFX_RUN1: begin
                if (long_op) begin
                    nxt_state = BSFX_RUN2;
                end else begin
                    nxt_state = BSFX_IDLE;
                    if (alu_bus.wr_res) begin
                        nxt_wreg[rd] = alu_bus.res;
                    end
                    if (alu_bus.wr_flags) begin
                        nxt_flags = alu_bus.flags_n;
                    end
                    if (op == bsfx_pkg::OP_SLEEP) begin
                        nxt_sleep = 1'b1;
                    end
                end
            end
            BSFX_RUN2: begin
                nxt_state = BSFX_IDLE;
                case (op)
                    bsfx_pkg::OP_PUSH: begin
                        nxt_stk[sp_ff] = wreg_ff[rd];
                        nxt_sp = sp_ff - 1'b1;
                    end
                    bsfx_pkg::OP_POP: begin
                        nxt_sp = sp_ff + 1'b1;
                        nxt_wreg[rd] = stk_ff[SPW'(sp_ff + 1'b1)];
                    end
                    bsfx_pkg::OP_IO_BIT_SET: begin
                        nxt_io[ioa][bsel] = 1'b1;
                    end
                    bsfx_pkg::OP_IO_BIT_CLEAR: begin
                        nxt_io[ioa][bsel] = 1'b0;
                    end
                    default: begin
                        nxt_sp = sp_ff;
                    end
                endcase
            end
            default: begin
                nxt_state = BSFX_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_ff <= BSFX_IDLE;
            cmd_ff   <= '0;
            sp_ff    <= SP_RST;
            flags_ff <= bsfx_pkg::FLAGS_RST;
            sleep_ff <= 1'b0;
            for (int i = 0; i < NUM_WREG; i++) begin
                wreg_ff[i] <= 8'h00;
            end
            for (int i = 0; i < NUM_IO; i++) begin
                io_ff[i] <= 8'h00;
            end
            for (int i = 0; i < STK_DEPTH; i++) begin
                stk_ff[i] <= 8'h00;
            end
        end else begin
            state_ff <= nxt_state;
            cmd_ff   <= nxt_cmd;
            sp_ff    <= nxt_sp;
            flags_ff <= nxt_flags;
            sleep_ff <= nxt_sleep;
            wreg_ff  <= nxt_wreg;
            io_ff    <= nxt_io;
            stk_ff   <= nxt_stk;
        end
    end

    // ----------------------------------------
    // wake synchroniser
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wk_s1_ff <= 1'b0;
            wk_s2_ff <= 1'b0;
        end else begin
            wk_s1_ff <= wake_i;
            wk_s2_ff <= wk_s1_ff;
        end
    end

    assign busy_o  = (state_ff != BSFX_IDLE);
    assign sleep_o = sleep_ff;
endmodule : bsfx_exec_unit

// ### dv/bsfx_exec_unit_properties.sv
`timescale 1ns/1ps
// ----------------------------------------
// command timing and bus properties
// ----------------------------------------
module bsfx_exec_unit_properties (
    input wire logic        ref_clk_i,
    input wire logic        reset_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        wake_i,
    input wire logic        busy_o,
    input wire logic        sleep_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);
    logic       acc;
    logic [3:0] op;
    logic       rd_acc;
    assign acc = psel_i && penable_i && pwrite_i && pready_o && !pslverr_o
                 && paddr_i == bsfx_pkg::OFS_CMD;
    assign op = pwdata_i[3:0];
    assign rd_acc = psel_i && penable_i && !pwrite_i;
    AST_LONG_OP_TIME: assert property (
        acc && op inside {[4'h1:4'h4]} |=> busy_o [*2] ##1 !busy_o)
        else $error("long op busy window wrong");
    AST_SHORT_OP_TIME: assert property (
        acc && op >= 4'h5 |=> busy_o ##1 !busy_o)
        else $error("short op busy window wrong");
    AST_SLEEP_ENTRY: assert property (
        acc && op == bsfx_pkg::OP_SLEEP |-> ##2 sleep_o)
        else $error("sleep not entered");
    AST_SLEEP_HOLDS: assert property (
        (sleep_o && !wake_i) [*3] |=> sleep_o)
        else $error("sleep left without wake");
    AST_WAKE_EXIT: assert property (
        $rose(wake_i) && sleep_o |-> ##[1:4] !sleep_o)
        else $error("wake did not end sleep");
    AST_BUSY_CAUSE: assert property (
        $rose(busy_o) |-> $past(acc))
        else $error("busy without command");
    AST_REFUSE_BUSY: assert property (
        psel_i && !penable_i && pwrite_i && (busy_o || sleep_o) ##1 psel_i && penable_i
        |-> pslverr_o)
        else $error("write accepted while busy");
    AST_STATUS_VIEW: assert property (
        rd_acc && paddr_i == bsfx_pkg::OFS_STATUS
        |-> prdata_o[0] == $past(busy_o) && prdata_o[1] == $past(sleep_o))
        else $error("status bits wrong");
    AST_FLAGS_UPPER_ZERO: assert property (
        rd_acc && paddr_i == bsfx_pkg::OFS_FLAGS |-> prdata_o[31:8] == 24'h000000)
        else $error("flag word upper bits set");
    COV_LONG: cover property (acc && op == bsfx_pkg::OP_PUSH);
    COV_SHORT: cover property (acc && op == bsfx_pkg::OP_ROTATE_LEFT_CARRY);
    COV_SLEEP: cover property ($fell(sleep_o));
    COV_REFUSED: cover property (pslverr_o);
endmodule : bsfx_exec_unit_properties

bind bsfx_exec_unit bsfx_exec_unit_properties u_props (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .pwdata_i  (pwdata_i),
    .prdata_o  (prdata_o),
    .pready_o  (pready_o),
    .pslverr_o (pslverr_o),
    .wake_i    (wake_i),
    .busy_o    (busy_o),
    .sleep_o   (sleep_o)
);

// ### dv/bit_shift_flag_exec_unit_tb.sv
`timescale 1ns/1ps
module bit_shift_flag_exec_unit_tb;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam logic [11:0] adr_flags = bsfx_pkg::OFS_FLAGS;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        wake;
    logic        busy;
    logic        sleep;
    int          n_errors;
    int          compares;

    bsfx_exec_unit u_dut (
        .ref_clk_i (clk),
        .reset_i   (rst),
        .psel_i    (psel),
        .penable_i (penable),
        .pwrite_i  (pwrite),
        .paddr_i   (paddr),
        .pwdata_i  (pwdata),
        .prdata_o  (prdata),
        .pready_o  (pready),
        .pslverr_o (pslverr),
        .wake_i    (wake),
        .busy_o    (busy),
        .sleep_o   (sleep)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic conclude();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    function automatic logic [11:0] adr(input logic [3:0] win, input int i);
        return {win, 6'(i), 2'b00};
    endfunction : adr

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic err, output logic [31:0] q);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_errors++;
            conclude();
        end
        q = prdata;
        chk("pslverr", 32'(err), 32'(pslverr));
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, 1'b0, q);
    endtask : wr

    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, 1'b0, q);
        chk(nm, e, q);
    endtask : rdc

    function automatic logic [31:0] cmd(input logic [3:0] op, input int r, input int b,
                                        input int io);
        return (32'(op) << bsfx_pkg::CMD_OP_LSB) | (32'(r) << bsfx_pkg::CMD_RD_LSB)
             | (32'(b) << bsfx_pkg::CMD_BIT_LSB) | (32'(io) << bsfx_pkg::CMD_IO_LSB);
    endfunction : cmd

    task automatic run(input logic [3:0] op, input int r, input int b, input int io,
                       input int cyc);
        int n;
        wr(bsfx_pkg::OFS_CMD, cmd(op, r, b, io));
        chk("busy start", 32'h1, 32'(busy));
        n = 0;
        while (busy === 1'b1 && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("busy cycles", 32'(cyc), 32'(n));
    endtask : run

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [31:0] q;
        rdc("flags rst", adr_flags, 32'(bsfx_pkg::FLAGS_RST));
        rdc("sp rst", bsfx_pkg::OFS_STATUS, 32'h00000F00);
        rdc("sp reg", bsfx_pkg::OFS_SP, 32'h0000000F);
        apb(1'b0, 12'h102, 32'h0, 1'b1, q);
        apb(1'b0, 12'h010, 32'h0, 1'b1, q);
        apb(1'b1, bsfx_pkg::OFS_STATUS, 32'h3, 1'b1, q);
    endtask : t_reset

    task automatic t_stack();
        wr(adr(bsfx_pkg::WIN_WREG, 3), 32'hA5);
        wr(adr_flags, 32'h5A);
        run(bsfx_pkg::OP_PUSH, 3, 0, 0, 2);
        rdc("sp push", bsfx_pkg::OFS_STATUS, 32'h00000E00);
        rdc("stack", adr(bsfx_pkg::WIN_STK, 15), 32'hA5);
        run(bsfx_pkg::OP_POP, 7, 0, 0, 2);
        rdc("pop", adr(bsfx_pkg::WIN_WREG, 7), 32'hA5);
        rdc("sp pop", bsfx_pkg::OFS_STATUS, 32'h00000F00);
        rdc("cmd back", bsfx_pkg::OFS_CMD, cmd(bsfx_pkg::OP_POP, 7, 0, 0));
        rdc("flags stk", adr_flags, 32'h5A);
    endtask : t_stack

    task automatic t_io();
        logic [31:0] q;
        wr(adr(bsfx_pkg::WIN_IO, 5), 32'h0F);
        run(bsfx_pkg::OP_IO_BIT_SET, 0, 7, 5, 2);
        rdc("io set", adr(bsfx_pkg::WIN_IO, 5), 32'h8F);
        wr(bsfx_pkg::OFS_CMD, cmd(bsfx_pkg::OP_IO_BIT_CLEAR, 0, 0, 5));
        apb(1'b1, adr(bsfx_pkg::WIN_IO, 6), 32'hFF, 1'b1, q);
        rdc("io clr", adr(bsfx_pkg::WIN_IO, 5), 32'h8E);
        rdc("io kept", adr(bsfx_pkg::WIN_IO, 6), 32'h0);
        rdc("flags io", adr_flags, 32'h5A);
    endtask : t_io

    task automatic t_shifts();
        logic [3:0] op;
        logic [7:0] v;
        logic [7:0] r;
        logic       ci;
        logic       c;
        for (int k = 0; k < 10; k++) begin
            op = 4'(5 + k / 2);
            v = k[0] ? 8'h41 : 8'h80;
            ci = k[0] ^ k[1];
            case (op)
                bsfx_pkg::OP_SHIFT_LEFT_LOGICAL:  r = {v[6:0], 1'b0};
                bsfx_pkg::OP_SHIFT_RIGHT_LOGICAL: r = {1'b0, v[7:1]};
                bsfx_pkg::OP_ROTATE_LEFT_CARRY:   r = {v[6:0], ci};
                bsfx_pkg::OP_ROTATE_RIGHT_CARRY:  r = {ci, v[7:1]};
                default:                          r = {v[7], v[7:1]};
            endcase
            c = (op == 4'h5 || op == 4'h7) ? v[7] : v[0];
            wr(adr(bsfx_pkg::WIN_WREG, 9), 32'(v));
            wr(adr_flags, {24'h0, 7'h78, ci});
            run(op, 9, 0, 0, 1);
            rdc("shift res", adr(bsfx_pkg::WIN_WREG, 9), 32'(r));
            rdc("shift flg", adr_flags, {24'h0, 4'hF, r[7] ^ c, r[7], r == 8'h00, c});
        end
    endtask : t_shifts

    task automatic t_bits();
        logic t;
        wr(adr(bsfx_pkg::WIN_WREG, 2), 32'h3C);
        wr(adr_flags, 32'h11);
        run(bsfx_pkg::OP_NIBBLE_SWAP, 2, 0, 0, 1);
        rdc("swap", adr(bsfx_pkg::WIN_WREG, 2), 32'hC3);
        rdc("flags swap", adr_flags, 32'h11);
        for (int b = 6; b >= 2; b -= 4) begin
            t = (b == 6);
            wr(adr(bsfx_pkg::WIN_WREG, 4), t ? 32'h0 : 32'hFF);
            run(bsfx_pkg::OP_BIT_TO_XFER_FLAG, 2, b, 0, 1);
            rdc("t flag", adr_flags, 32'h11 | (32'(t) << bsfx_pkg::FLG_T));
            run(bsfx_pkg::OP_XFER_FLAG_TO_BIT, 4, b, 0, 1);
            rdc("bit load", adr(bsfx_pkg::WIN_WREG, 4),
                t ? (32'h1 << b) : (32'hFF & ~(32'h1 << b)));
            rdc("flags load", adr_flags, 32'h11 | (32'(t) << bsfx_pkg::FLG_T));
        end
    endtask : t_bits

    task automatic t_flags();
        for (int b = 0; b < 8; b++) begin
            wr(adr_flags, 32'h0);
            run(bsfx_pkg::OP_FLAG_SET, 0, b, 0, 1);
            rdc("flag set", adr_flags, 32'h1 << b);
            wr(adr_flags, 32'hFF);
            run(bsfx_pkg::OP_FLAG_CLEAR, 0, b, 0, 1);
            rdc("flag clr", adr_flags, 32'hFF & ~(32'h1 << b));
        end
    endtask : t_flags

    task automatic t_sleep();
        logic [31:0] q;
        int          n;
        wr(adr_flags, 32'h2B);
        run(bsfx_pkg::OP_SLEEP, 0, 0, 0, 1);
        chk("sleep", 32'h1, 32'(sleep));
        apb(1'b1, adr(bsfx_pkg::WIN_WREG, 1), 32'h77, 1'b1, q);
        rdc("flags sleep", adr_flags, 32'h2B);
        @(posedge clk);
        wake <= 1'b1;
        n = 0;
        while (sleep === 1'b1 && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("wake", 32'h0, 32'(sleep));
        @(posedge clk);
        wake <= 1'b0;
    endtask : t_sleep

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        wake = 1'b0;
        n_errors = 0;
        compares = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_stack();
        t_io();
        t_shifts();
        t_bits();
        t_flags();
        t_sleep();
        conclude();
    end
endmodule : bit_shift_flag_exec_unit_tb
